// ==== common/rcl_pkg.sv ====
package rcl_pkg;

	// ************************************************************
	// Widths
	// ************************************************************
	localparam int ADDR_W  = 12;
	localparam int INC_W   = 4;
	localparam int TIME_W  = 16;
	localparam int GAIN_W  = 16;
	localparam int FMT_W   = 8;
	localparam int MHZ_W   = 8;
	localparam int NGAIN   = 4;
	localparam int PROD_W  = 32;

	// ************************************************************
	// Skip factors and increments
	// ************************************************************
	localparam logic [INC_W-1:0] ODD_INC_FULL = 4'h1;
	localparam logic [INC_W-1:0] ODD_INC_SKIP = 4'h3;
	localparam logic [1:0]       SKIP_ONE     = 2'h1;
	localparam logic [1:0]       SKIP_TWO     = 2'h2;
	localparam logic [1:0]       SKIP_PERIOD_MASK = 2'h3;
	localparam logic [1:0]       START_PHASE  = 2'h0;
	localparam logic [1:0]       END_PHASE    = 2'h1;

	// ************************************************************
	// Forced parity bits
	// ************************************************************
	localparam logic START_BIT0 = 1'b0;
	localparam logic END_BIT0   = 1'b1;
	localparam logic INC_BIT0   = 1'b1;
	localparam logic SIZE_BIT0  = 1'b0;

	// ************************************************************
	// Output size limits and link alignment
	// ************************************************************
	localparam logic [ADDR_W-1:0] X_OUT_MIN  = 12'h100;
	localparam logic [ADDR_W-1:0] X_OUT_MAX  = 12'h648;
	localparam logic [ADDR_W-1:0] Y_OUT_MIN  = 12'h002;
	localparam logic [FMT_W-1:0]  FMT_RAW8   = 8'h08;
	localparam logic [FMT_W-1:0]  FMT_RAW10  = 8'h0a;
	localparam logic [ADDR_W-1:0] ALIGN_M8   = 12'h003;
	localparam logic [ADDR_W-1:0] ALIGN_M10  = 12'h00f;
	localparam logic [3:0]        BPP_8      = 4'h8;
	localparam logic [3:0]        BPP_10     = 4'ha;
	localparam int                OVH_BYTES  = 12;
	localparam logic [PROD_W-1:0] OVH_BITS   = PROD_W'(OVH_BYTES * 8);
	// Alternating value at one third of full scale, far from the all-ones and all-zeros sync words.
	localparam logic [9:0]        PAD_PIXEL  = 10'h155;

	// ************************************************************
	// Violation flag positions
	// ************************************************************
	localparam int V_INC    = 0;
	localparam int V_LINE   = 1;
	localparam int V_FRAME  = 2;
	localparam int V_GAIN   = 3;
	localparam int V_XOUT   = 4;
	localparam int V_YOUT   = 5;
	localparam int V_ALIGN  = 6;
	localparam int V_ROWT   = 7;
	localparam int V_WIN    = 8;
	localparam int V_SUBS   = 9;
	localparam int NVIOL    = 10;

	typedef struct packed {
		logic [ADDR_W-1:0]            x_start;
		logic [ADDR_W-1:0]            x_end;
		logic [ADDR_W-1:0]            y_start;
		logic [ADDR_W-1:0]            y_end;
		logic [INC_W-1:0]             x_odd;
		logic [INC_W-1:0]             x_even;
		logic [INC_W-1:0]             y_odd;
		logic [INC_W-1:0]             y_even;
		logic [TIME_W-1:0]            line_len;
		logic [TIME_W-1:0]            frame_len;
		logic [ADDR_W-1:0]            x_out;
		logic [ADDR_W-1:0]            y_out;
		logic [FMT_W-1:0]             fmt;
		logic                         strobe_mode;
		logic [NGAIN-1:0][GAIN_W-1:0] gain;
	} rcl_cfg_t;

	typedef struct packed {
		logic [TIME_W-1:0] min_line_blank;
		logic [TIME_W-1:0] min_frame_blank;
		logic [GAIN_W-1:0] gain_min;
		logic [GAIN_W-1:0] gain_max;
		logic [GAIN_W-1:0] gain_step;
		logic [ADDR_W-1:0] x_addr_max;
		logic [ADDR_W-1:0] y_addr_max;
		logic [MHZ_W-1:0]  vt_mhz;
		logic [MHZ_W-1:0]  op_mhz;
	} rcl_lim_t;

endpackage : rcl_pkg

// ==== core/rcl_checker.sv ====
`timescale 1ns/10ps
module rcl_checker (
	input  wire logic                      ref_clk_in,
	input  wire logic                      rst_in,
	input  wire logic                      cfg_we_in,
	input  wire rcl_pkg::rcl_cfg_t         cfg_in,
	input  wire rcl_pkg::rcl_lim_t         lim_in,
	input  wire logic [rcl_pkg::NVIOL-1:0] viol_ack_in,
	output rcl_pkg::rcl_cfg_t              cfg_out,
	output logic [rcl_pkg::NVIOL-1:0]      viol_out,
	output logic                           cfg_legal_out,
	output logic [rcl_pkg::ADDR_W-1:0]     x_out_aligned_out,
	output logic [9:0]                     pad_pixel_out
);

	// ************************************************************
	// Configuration store with forced bits
	// ************************************************************
	rcl_pkg::rcl_cfg_t cfg_r;
	rcl_pkg::rcl_cfg_t cfg_nxt;

	always_comb
	begin
		cfg_nxt            = cfg_in;
		cfg_nxt.x_start[0] = rcl_pkg::START_BIT0;
		cfg_nxt.y_start[0] = rcl_pkg::START_BIT0;
		cfg_nxt.x_end[0]   = rcl_pkg::END_BIT0;
		cfg_nxt.y_end[0]   = rcl_pkg::END_BIT0;
		cfg_nxt.x_odd[0]   = rcl_pkg::INC_BIT0;
		cfg_nxt.y_odd[0]   = rcl_pkg::INC_BIT0;
		cfg_nxt.x_even[0]  = rcl_pkg::INC_BIT0;
		cfg_nxt.y_even[0]  = rcl_pkg::INC_BIT0;
		cfg_nxt.x_out[0]   = rcl_pkg::SIZE_BIT0;
		cfg_nxt.y_out[0]   = rcl_pkg::SIZE_BIT0;
	end

	// Reset gives a minimal two-address (start 0, end 1), no-skip window so the flags start meaningful.
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cfg_r             <= '0;
			cfg_r.x_end[0]    <= rcl_pkg::END_BIT0;
			cfg_r.y_end[0]    <= rcl_pkg::END_BIT0;
			cfg_r.x_odd       <= rcl_pkg::ODD_INC_FULL;
			cfg_r.y_odd       <= rcl_pkg::ODD_INC_FULL;
			cfg_r.x_even      <= rcl_pkg::ODD_INC_FULL;
			cfg_r.y_even      <= rcl_pkg::ODD_INC_FULL;
		end
		else if (cfg_we_in)
		begin
			cfg_r <= cfg_nxt;
		end
	end

	// ************************************************************
	// Skip factors and window size
	// ************************************************************
	logic [1:0]                 xskip;
	logic [1:0]                 yskip;
	logic                       inc_bad;
	logic [rcl_pkg::ADDR_W:0]   x_span;
	logic [rcl_pkg::ADDR_W:0]   y_span;
	logic [rcl_pkg::TIME_W:0]   x_width;
	logic [rcl_pkg::TIME_W:0]   y_height;

	always_comb
	begin
		xskip   = (cfg_r.x_odd == rcl_pkg::ODD_INC_SKIP)
		        ? rcl_pkg::SKIP_TWO : rcl_pkg::SKIP_ONE;
		yskip   = (cfg_r.y_odd == rcl_pkg::ODD_INC_SKIP)
		        ? rcl_pkg::SKIP_TWO : rcl_pkg::SKIP_ONE;
		inc_bad = !((cfg_r.x_odd == rcl_pkg::ODD_INC_FULL) || (cfg_r.x_odd == rcl_pkg::ODD_INC_SKIP))
		       || !((cfg_r.y_odd == rcl_pkg::ODD_INC_FULL) || (cfg_r.y_odd == rcl_pkg::ODD_INC_SKIP));
		x_span  = (rcl_pkg::ADDR_W+1)'(cfg_r.x_end - cfg_r.x_start + cfg_r.x_odd);
		y_span  = (rcl_pkg::ADDR_W+1)'(cfg_r.y_end - cfg_r.y_start + cfg_r.y_odd);
		x_width = (rcl_pkg::TIME_W+1)'((xskip == rcl_pkg::SKIP_TWO) ? (x_span >> 1) : x_span);
		y_height = (rcl_pkg::TIME_W+1)'((yskip == rcl_pkg::SKIP_TWO) ? (y_span >> 1) : y_span);
	end

	// ************************************************************
	// Individual checks
	// ************************************************************
	logic [rcl_pkg::NVIOL-1:0]  fail;
	logic [rcl_pkg::NGAIN-1:0]  gain_bad;
	logic [rcl_pkg::ADDR_W-1:0] align_mask;
	logic [3:0]                 bpp;
	logic [rcl_pkg::PROD_W-1:0] out_bits;
	logic [rcl_pkg::PROD_W-1:0] out_cost;
	logic [rcl_pkg::PROD_W-1:0] arr_cost;
	logic                       win_bad;
	logic                       subs_bad;

	genvar gi;
	generate
		for (gi = 0; gi < rcl_pkg::NGAIN; gi++)
		begin : g_gain
			// A zero step is treated as unconstrained granularity.
			assign gain_bad[gi] = (cfg_r.gain[gi] < lim_in.gain_min)
				|| (cfg_r.gain[gi] > lim_in.gain_max)
				|| ((lim_in.gain_step != '0)
				&& ((cfg_r.gain[gi] % lim_in.gain_step) != '0));
		end
	endgenerate

	always_comb
	begin
		align_mask = (cfg_r.fmt == rcl_pkg::FMT_RAW8)
		           ? rcl_pkg::ALIGN_M8 : rcl_pkg::ALIGN_M10;
		bpp        = (cfg_r.fmt == rcl_pkg::FMT_RAW8) ? rcl_pkg::BPP_8 : rcl_pkg::BPP_10;
		out_bits   = rcl_pkg::PROD_W'(cfg_r.x_out) * rcl_pkg::PROD_W'(bpp) + rcl_pkg::OVH_BITS;
		// Cross-multiplied so no divider is needed; strobe signalling moves two bits per clock.
		out_cost   = out_bits * rcl_pkg::PROD_W'(lim_in.vt_mhz);
		arr_cost   = rcl_pkg::PROD_W'(cfg_r.line_len) * rcl_pkg::PROD_W'(lim_in.op_mhz)
		           * (cfg_r.strobe_mode ? rcl_pkg::PROD_W'(2) : rcl_pkg::PROD_W'(1));
		win_bad    = (cfg_r.x_end < cfg_r.x_start) || (cfg_r.x_end > lim_in.x_addr_max)
		          || (cfg_r.y_end < cfg_r.y_start) || (cfg_r.y_end > lim_in.y_addr_max)
		          || (x_span == '0) || (y_span == '0);
		// Skipped readout repeats every four addresses.
		subs_bad   = ((xskip == rcl_pkg::SKIP_TWO)
		          && (((cfg_r.x_start[1:0] & rcl_pkg::SKIP_PERIOD_MASK) != rcl_pkg::START_PHASE)
		          || ((cfg_r.x_end[1:0] & rcl_pkg::SKIP_PERIOD_MASK) != rcl_pkg::END_PHASE)))
		          || ((yskip == rcl_pkg::SKIP_TWO)
		          && (((cfg_r.y_start[1:0] & rcl_pkg::SKIP_PERIOD_MASK) != rcl_pkg::START_PHASE)
		          || ((cfg_r.y_end[1:0] & rcl_pkg::SKIP_PERIOD_MASK) != rcl_pkg::END_PHASE)));

		fail                  = '0;
		fail[rcl_pkg::V_INC]  = inc_bad;
		fail[rcl_pkg::V_LINE] = (rcl_pkg::TIME_W+2)'(cfg_r.line_len)
			< ((rcl_pkg::TIME_W+2)'(x_width) + (rcl_pkg::TIME_W+2)'(lim_in.min_line_blank));
		fail[rcl_pkg::V_FRAME] = (rcl_pkg::TIME_W+2)'(cfg_r.frame_len)
			< ((rcl_pkg::TIME_W+2)'(y_height) + (rcl_pkg::TIME_W+2)'(lim_in.min_frame_blank));
		fail[rcl_pkg::V_GAIN] = |gain_bad;
		fail[rcl_pkg::V_XOUT] = (cfg_r.x_out < rcl_pkg::X_OUT_MIN)
			|| (cfg_r.x_out > rcl_pkg::X_OUT_MAX);
		fail[rcl_pkg::V_YOUT] = (cfg_r.y_out < rcl_pkg::Y_OUT_MIN)
			|| (rcl_pkg::TIME_W'(cfg_r.y_out) > cfg_r.frame_len);
		fail[rcl_pkg::V_ALIGN] = (cfg_r.x_out & align_mask) != '0;
		fail[rcl_pkg::V_ROWT] = out_cost >= arr_cost;
		fail[rcl_pkg::V_WIN]  = win_bad;
		fail[rcl_pkg::V_SUBS] = subs_bad;
	end

	// ************************************************************
	// Sticky flags, set beats acknowledge
	// ************************************************************
	logic [rcl_pkg::NVIOL-1:0] viol_r;

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			viol_r <= '0;
		end
		else
		begin
			viol_r <= (viol_r & ~viol_ack_in) | fail;
		end
	end

	// ************************************************************
	// Registered outputs
	// ************************************************************
	logic [rcl_pkg::ADDR_W-1:0] aligned_nxt;
	logic [rcl_pkg::ADDR_W-1:0] aligned_r;
	logic                       legal_r;

	// The sum cannot wrap for widths up to the 1608 limit in a 12-bit field.
	assign aligned_nxt = (cfg_r.x_out + align_mask) & ~align_mask;

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			aligned_r <= '0;
			legal_r   <= 1'b0;
		end
		else
		begin
			aligned_r <= aligned_nxt;
			legal_r   <= ~|fail;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			pad_pixel_out <= rcl_pkg::PAD_PIXEL;
		end
		else
		begin
			pad_pixel_out <= rcl_pkg::PAD_PIXEL;
		end
	end

	assign cfg_out           = cfg_r;
	assign viol_out          = viol_r;
	assign cfg_legal_out     = legal_r;
	assign x_out_aligned_out = aligned_r;

endmodule : rcl_checker

// ==== tb/rcl_checker_properties.sv ====
`timescale 1ns/10ps
module rcl_chk_props (
	input wire logic                       ref_clk_in,
	input wire logic                       rst_in,
	input wire logic                       cfg_we_in,
	input wire rcl_pkg::rcl_cfg_t          cfg_in,
	input wire rcl_pkg::rcl_lim_t          lim_in,
	input wire logic [rcl_pkg::NVIOL-1:0]  viol_ack_in,
	input wire rcl_pkg::rcl_cfg_t          cfg_out,
	input wire logic [rcl_pkg::NVIOL-1:0]  viol_out,
	input wire logic                       cfg_legal_out,
	input wire logic [rcl_pkg::ADDR_W-1:0] x_out_aligned_out,
	input wire logic [9:0]                 pad_pixel_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	AST_START_EVEN: assert property (!cfg_out.x_start[0] && !cfg_out.y_start[0])
		else $error("start address bit 0 not clear");
	AST_END_ODD: assert property (cfg_out.x_end[0] && cfg_out.y_end[0])
		else $error("end address bit 0 not set");
	AST_INC_ODD: assert property (cfg_out.x_odd[0] && cfg_out.x_even[0]
		&& cfg_out.y_odd[0] && cfg_out.y_even[0])
		else $error("increment bit 0 not set");
	AST_SIZE_EVEN: assert property (!cfg_out.x_out[0] && !cfg_out.y_out[0])
		else $error("output size bit 0 not clear");
	AST_LOAD: assert property (cfg_we_in |=>
		cfg_out.x_out == ($past(cfg_in.x_out) & 12'hffe)
		&& cfg_out.line_len == $past(cfg_in.line_len))
		else $error("stored config does not follow write");
	AST_HOLD: assert property (!cfg_we_in |=> $stable(cfg_out))
		else $error("stored config changed without write");
	AST_STICKY: assert property (($past(viol_out) & ~$past(viol_ack_in) & ~viol_out) == '0)
		else $error("violation flag dropped without acknowledge");
	AST_NEW_FAIL: assert property (|(viol_out & ~$past(viol_out)) |-> !cfg_legal_out)
		else $error("new violation while config reported legal");
	AST_ALIGN_MULT: assert property ((x_out_aligned_out
		& (($past(cfg_out.fmt) == 8'h08) ? 12'h003 : 12'h00f)) == 12'h000)
		else $error("aligned width not a legal multiple");
	AST_ROUND_UP: assert property (x_out_aligned_out >= $past(cfg_out.x_out)
		&& x_out_aligned_out - $past(cfg_out.x_out) <= 12'h00f)
		else $error("aligned width not rounded upward");
	AST_PAD: assert property (pad_pixel_out == 10'h155)
		else $error("pad pixel value changed");
	COV_SUBS: cover property (viol_out[9]);
	COV_LEGAL: cover property (cfg_legal_out);
	COV_ACK: cover property ($fell(viol_out[3]));
endmodule : rcl_chk_props

bind rcl_checker rcl_chk_props u_props (.ref_clk_in, .rst_in, .cfg_we_in, .cfg_in, .lim_in,
	.viol_ack_in, .cfg_out, .viol_out, .cfg_legal_out, .x_out_aligned_out, .pad_pixel_out);

// ==== tb/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
	$display("FAIL %0t got %0h want %0h", $time, a, e); end end
module tb_top;
	logic                       ref_clk_in = 1'b0;
	logic                       rst_in = 1'b1;
	logic                       cfg_we_in = 1'b0;
	logic [rcl_pkg::NVIOL-1:0]  viol_ack_in = '0;
	rcl_pkg::rcl_cfg_t          cfg_in, good, gx, gy, gf, c, exp_c;
	rcl_pkg::rcl_lim_t          lim_in;
	rcl_pkg::rcl_cfg_t          cfg_out;
	logic [rcl_pkg::NVIOL-1:0]  viol_out;
	logic                       cfg_legal_out;
	logic [rcl_pkg::ADDR_W-1:0] x_out_aligned_out;
	logic [9:0]                 pad_pixel_out;
	int                         compares = 0;
	int                         miscompares = 0;
	// Flag index and expected value per case; flag positions follow the package.
	localparam int         BIT_OF[25] = '{1, 1, 9, 9, 2, 2, 6, 6, 0, 3, 3, 3, 4,
		4, 4, 4, 5, 5, 5, 6, 7, 7, 8, 7, 7};
	localparam logic [0:24] EXP = 25'b0110010111101010110110110;
	always #2.5 ref_clk_in = ~ref_clk_in;
	rcl_checker u_dut (.ref_clk_in, .rst_in, .cfg_we_in, .cfg_in, .lim_in, .viol_ack_in,
		.cfg_out, .viol_out, .cfg_legal_out, .x_out_aligned_out, .pad_pixel_out);
	task automatic put(input rcl_pkg::rcl_cfg_t v);
		@(negedge ref_clk_in);
		cfg_in = v;
		cfg_we_in = 1'b1;
		@(negedge ref_clk_in);
		cfg_we_in = 1'b0;
		repeat (2) @(negedge ref_clk_in);
	endtask : put
	task automatic ack(input logic [rcl_pkg::NVIOL-1:0] m);
		viol_ack_in = m;
		@(negedge ref_clk_in);
		viol_ack_in = '0;
		@(negedge ref_clk_in);
	endtask : ack
	function automatic rcl_pkg::rcl_cfg_t mk(input int k);
		rcl_pkg::rcl_cfg_t r;
		r = (k < 4) ? gx : (k < 6) ? gy : (k < 8) ? gf : good;
		r.strobe_mode = (k > 22);
		case (k)
			0: r.line_len = 16'h0330;
			1: r.line_len = 16'h032f;
			2: r.x_end = 12'h63f;
			4: r.frame_len = 16'h0268;
			5: r.frame_len = 16'h0267;
			6: r.x_out = 12'h104;
			7: r.x_out = 12'h102;
			8: r.x_odd = 4'h5;
			9: r.gain[0] = 16'h0108;
			10: r.gain[2] = 16'h0410;
			11: r.gain[3] = 16'h0400;
			12: r.x_out = 12'h0fe;
			13: r.x_out = 12'h100;
			14: r.x_out = 12'h64a;
			15: r.x_out = 12'h648;
			16: r.y_out = 12'h000;
			17: r.y_out = 12'h504;
			18: r.y_out = 12'h502;
			19: r.x_out = 12'h108;
			20: r.line_len = 16'h03ee;
			21: r.line_len = 16'h03ef;
			22: r.x_end = 12'h649;
			23: r.line_len = 16'h01f7;
			24: r.line_len = 16'h01f8;
			default: r = r;
		endcase
		return r;
	endfunction : mk
	task automatic wrap_up();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	initial
	begin
		#20000;
		miscompares++;
		wrap_up();
	end
	initial
	begin
		lim_in = '{16'h0010, 16'h0010, 16'h0080, 16'h0400, 16'h0010, 12'h647, 12'h4b7, 8'h01, 8'h10};
		good = '{12'h000, 12'h63f, 12'h000, 12'h4af, 4'h1, 4'h1, 4'h1, 4'h1, 16'h0938, 16'h0503,
			12'h640, 12'h4b0, 8'h0a, 1'b0, {4{16'h0100}}};
		cfg_in = good;
		gx = good;
		gx.x_odd = 4'h3;
		gx.x_end = 12'h63d;
		gy = good;
		gy.y_odd = 4'h3;
		gy.y_end = 12'h4ad;
		gf = good;
		gf.fmt = 8'h08;
		exp_c = '0;
		exp_c.x_end = 12'h001;
		exp_c.y_end = 12'h001;
		{exp_c.x_odd, exp_c.x_even, exp_c.y_odd, exp_c.y_even} = {4{4'h1}};
		repeat (4) @(negedge ref_clk_in);
		`CHK(cfg_out, exp_c)
		`CHK(viol_out, 10'h000)
		`CHK(pad_pixel_out, 10'h155)
		rst_in = 1'b0;
		$display("test reset done");
		c = good;
		c.x_start = 12'h001;
		c.x_end = 12'h63e;
		c.x_even = 4'h0;
		c.x_out = 12'h641;
		c.y_out = 12'h4b1;
		put(c);
		`CHK(cfg_out, good)
		ack('1);
		`CHK(viol_out, 10'h000)
		`CHK(cfg_legal_out, 1'b1)
		`CHK(x_out_aligned_out, 12'h640)
		$display("test load done");
		for (int k = 0; k < 25; k++)
		begin
			put(mk(k));
			`CHK(viol_out[BIT_OF[k]], EXP[k])
			ack(10'h001 << BIT_OF[k]);
			`CHK(viol_out[BIT_OF[k]], EXP[k])
			put(good);
			`CHK(viol_out[BIT_OF[k]], EXP[k])
			ack('1);
			`CHK(viol_out, 10'h000)
		end
		$display("test limits done");
		c = good;
		c.x_out = 12'h108;
		put(c);
		`CHK(x_out_aligned_out, 12'h110)
		c = gf;
		c.x_out = 12'h102;
		put(c);
		`CHK(x_out_aligned_out, 12'h104)
		rst_in = 1'b1;
		@(negedge ref_clk_in);
		`CHK(cfg_out, exp_c)
		`CHK(cfg_legal_out, 1'b0)
		rst_in = 1'b0;
		$display("test align done");
		wrap_up();
	end
endmodule : tb_top
